//--- ccmt_regs.svh
// Register offsets, field positions, reset values and counts of the capture/compare timer
`ifndef CCMT_REGS_SVH
`define CCMT_REGS_SVH

// ==========================================================================
// Register byte offsets
`define CCMT_ADDR_TSC 8'h00
`define CCMT_ADDR_CNT 8'h04
`define CCMT_ADDR_MOD 8'h08
`define CCMT_ADDR_CH0_SC 8'h0C
`define CCMT_ADDR_CH0_VAL 8'h10
`define CCMT_CH_STRIDE 8'h08

// ==========================================================================
// Timer status and control fields
`define CCMT_TSC_OVF 7
`define CCMT_TSC_OVERFLOW_IRQ_ENABLE 6
`define CCMT_TSC_STOP 5
`define CCMT_TSC_RST 4
`define CCMT_TSC_PS_MSB 2
`define CCMT_TSC_PS_LSB 0

// ==========================================================================
// Channel status and control fields
`define CCMT_SC_FLAG 7
`define CCMT_SC_IE 6
`define CCMT_SC_LINK 5
`define CCMT_SC_MSA 4
`define CCMT_SC_ELSB 3
`define CCMT_SC_ELSA 2
`define CCMT_SC_TOV 1

// ==========================================================================
// Reset values and codes
`define CCMT_MOD_RST 16'hFFFF
`define CCMT_PS_RST 3'h0
`define CCMT_PS_UNUSED 3'h7
`define CCMT_PRESC_W 7
`define CCMT_RESP_OKAY 2'h0
`define CCMT_RESP_SLVERR 2'h2

`endif

//--- ccmt_pkg.sv
// Types of the capture/compare timer
package ccmt_pkg;

  // ==========================================================================
  // Channel control bits
  typedef struct packed {
    logic flag;
    logic ie;
    logic link;
    logic msa;
    logic elsb;
    logic elsa;
    logic tov;
  } ccmt_ctrl_s;

  // ==========================================================================
  // Whole state of one channel
  typedef struct packed {
    ccmt_ctrl_s ctrl;
    logic armed;
    logic inhibit;
    logic pin_out;
    logic sync1;
    logic sync2;
    logic last;
    logic [15:0] value;
  } ccmt_chan_s;

  // ==========================================================================
  // Whole state of the timer core and bus slave
  typedef struct packed {
    logic [15:0] count;
    logic [6:0] presc;
    logic cnt_new;
    logic [15:0] modulo;
    logic mod_inhibit;
    logic ovf_flag;
    logic ovf_armed;
    logic overflow_irq_enable;
    logic stop;
    logic [2:0] ps;
    logic active;
    logic pending;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ccmt_top_s;

endpackage

//--- ccmt_chan.sv
// One capture/compare channel: edge capture, compare action, flag and pin drive
`timescale 1ns/1ps
`include "ccmt_regs.svh"

module ccmt_chan #(
  parameter bit CAN_LINK = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Time base
  input wire logic [15:0] count_i,
  input wire logic cnt_new_i,
  input wire logic ovf_i,
  input wire logic [15:0] cmp_value_i,
  input wire logic disabled_i,
  // Register access
  input wire logic wr_ctrl_i,
  input wire logic rd_ctrl_i,
  input wire logic wr_val_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic [7:0] ctrl_o,
  output logic [15:0] value_o,
  output logic irq_o,
  // Pin
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o
);

  ccmt_pkg::ccmt_chan_s s_ff;
  ccmt_pkg::ccmt_chan_s nxt_s;
  logic [1:0] els;
  logic linked;
  logic cmp_mode;
  logic live;
  logic cap_hit;
  logic cmp_hit;
  logic ovf_tog;

  always_comb begin
    els = {s_ff.ctrl.elsb, s_ff.ctrl.elsa};
    linked = CAN_LINK && s_ff.ctrl.link;
    live = !disabled_i;
    cmp_mode = linked || s_ff.ctrl.msa;
    cap_hit = live && !cmp_mode && ((els[0] && s_ff.sync2 && !s_ff.last) ||
      (els[1] && !s_ff.sync2 && s_ff.last));
    cmp_hit = live && cmp_mode && cnt_new_i && !s_ff.inhibit &&
      (count_i == cmp_value_i);
    ovf_tog = live && cmp_mode && s_ff.ctrl.tov && ovf_i && (els != 2'h0);
    nxt_s = s_ff;
    // Pin synchroniser and edge history
    nxt_s.sync1 = pin_i;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.last = s_ff.sync2;
    // Output level; overflow toggle wins over a coincident compare
    if (els == 2'h0) begin
      nxt_s.pin_out = !s_ff.ctrl.msa;
    end else if (ovf_tog) begin
      nxt_s.pin_out = !s_ff.pin_out;
    end else if (cmp_hit) begin
      case (els)
        2'h1: nxt_s.pin_out = !s_ff.pin_out;
        2'h2: nxt_s.pin_out = 1'b0;
        2'h3: nxt_s.pin_out = 1'b1;
        default: nxt_s.pin_out = s_ff.pin_out;
      endcase
    end
    // Control register; flag clears by read-then-write-zero
    if (rd_ctrl_i && s_ff.ctrl.flag) begin
      nxt_s.armed = 1'b1;
    end
    if (wr_ctrl_i && live && wstrb_i[0]) begin
      if (!wdata_i[`CCMT_SC_FLAG] && s_ff.armed) begin
        nxt_s.ctrl.flag = 1'b0;
      end
      nxt_s.armed = 1'b0;
      nxt_s.ctrl.ie = wdata_i[`CCMT_SC_IE];
      nxt_s.ctrl.link = CAN_LINK && wdata_i[`CCMT_SC_LINK];
      nxt_s.ctrl.msa = wdata_i[`CCMT_SC_MSA];
      nxt_s.ctrl.elsb = wdata_i[`CCMT_SC_ELSB];
      nxt_s.ctrl.elsa = wdata_i[`CCMT_SC_ELSA];
      nxt_s.ctrl.tov = wdata_i[`CCMT_SC_TOV];
    end
    // Value register; a high-lane-only write holds compares off until the low lane
    if (wr_val_i) begin
      if (wstrb_i[1]) begin
        nxt_s.value[15:8] = wdata_i[15:8];
        nxt_s.inhibit = 1'b1;
      end
      if (wstrb_i[0]) begin
        nxt_s.value[7:0] = wdata_i[7:0];
        nxt_s.inhibit = 1'b0;
      end
    end
    // Capture on every active edge, flag state regardless
    if (cap_hit) begin
      nxt_s.value = count_i;
    end
    // A new event wins over a clear in the same cycle
    if (cap_hit || cmp_hit) begin
      nxt_s.ctrl.flag = 1'b1;
      nxt_s.armed = 1'b0;
    end
    if (reset_i) begin
      nxt_s = '0;
      nxt_s.pin_out = 1'b1;
      nxt_s.value = s_ff.value;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    s_ff <= nxt_s;
  end

  // Linked second channel's control reads as zero and frees its pin
  assign ctrl_o = disabled_i ? 8'h00 : {s_ff.ctrl, 1'b0};
  assign value_o = s_ff.value;
  assign irq_o = live && s_ff.ctrl.flag && s_ff.ctrl.ie;
  assign pin_o = s_ff.pin_out;
  assign pin_oe_o = live && cmp_mode && (els != 2'h0);

endmodule

//--- ccmt_timer.sv
// Two-channel 16-bit capture/compare timer with AXI4-Lite register slave
// Behaviour
// - 16-bit counter, free running or modulo
// - Counter reads never disturb counting
// - Two channels, each capture or compare
// - Counter clock from seven prescaler taps
// - Capture edge: rising, falling or both
// - Every active edge copies the counter
// - Captured value lands three cycles later
// - Events set flag; flag plus enable interrupts
// - Reset leaves channel values untouched
// - Compare match sets, clears or toggles pin
// - Optional pin toggle on counter overflow
// - Unbuffered compare value takes effect immediately
// - Link bit joins channels, channel 0 first
// - Last written pair takes over at overflow
// - Linked: channel 0 controls, channel 1 only holds the second value
// - Stop halts counting; reset clears counter, prescaler
// - Overflow flag at modulo, interrupt if enabled
// - Buffered bit outranks unbuffered bit
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ccmt_regs.svh"

module ccmt_timer #(
  parameter int ADDR_W = 8,
  parameter int NCH = 2
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Interrupt requests
  output logic ovf_irq_o,
  output logic [NCH-1:0] chan_irq_o,
  // Channel pins
  input wire logic [NCH-1:0] chan_pin_i,
  output logic [NCH-1:0] chan_pin_o,
  output logic [NCH-1:0] chan_pin_oe_o
);

  // ==========================================================================
  // State and decode signals
  ccmt_pkg::ccmt_top_s s_ff;
  ccmt_pkg::ccmt_top_s nxt_s;
  logic wr_go;
  logic rd_go;
  logic [7:0] waddr;
  logic [7:0] raddr;
  logic [6:0] pmask;
  logic tick;
  logic ovf;
  logic link0;
  logic [NCH-1:0] wr_ctrl;
  logic [NCH-1:0] rd_ctrl;
  logic [NCH-1:0] wr_val;
  logic [NCH-1:0] rd_ctrl_hit;
  logic [NCH-1:0] rd_val_hit;
  logic [NCH-1:0] disabled;
  logic [7:0] ch_ctrl [NCH];
  logic [15:0] ch_value [NCH];
  logic [15:0] cmp_value [NCH];
  logic [31:0] rd_mux;
  logic rd_ok;

  // ==========================================================================
  // Bus handshakes: address and data are taken together, one of each in flight
  assign wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !s_ff.bvalid;
  assign rd_go = s_axi_arvalid_i && !s_ff.rvalid;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o = wr_go;
  assign s_axi_arready_o = !s_ff.rvalid;
  assign s_axi_bvalid_o = s_ff.bvalid;
  assign s_axi_bresp_o = s_ff.bresp;
  assign s_axi_rvalid_o = s_ff.rvalid;
  assign s_axi_rresp_o = s_ff.rresp;
  assign s_axi_rdata_o = s_ff.rdata;
  assign waddr = {s_axi_awaddr_i[7:2], 2'h0};
  assign raddr = {s_axi_araddr_i[7:2], 2'h0};

  // ==========================================================================
  // Prescaler tap and overflow
  assign pmask = ~(7'h7F << s_ff.ps);
  assign tick = !s_ff.stop && (s_ff.ps != `CCMT_PS_UNUSED) &&
    ((s_ff.presc & pmask) == pmask);
  assign ovf = s_ff.cnt_new && (s_ff.count == s_ff.modulo);
  assign link0 = ch_ctrl[0][`CCMT_SC_LINK];

  // ==========================================================================
  // Per-channel decode and compare source
  for (genvar g = 0; g < NCH; g++) begin : g_dec
    localparam logic [7:0] SC_ADDR = 8'(`CCMT_ADDR_CH0_SC + g * `CCMT_CH_STRIDE);
    localparam logic [7:0] VAL_ADDR = 8'(`CCMT_ADDR_CH0_VAL + g * `CCMT_CH_STRIDE);
    assign wr_ctrl[g] = wr_go && (waddr == SC_ADDR);
    assign wr_val[g] = wr_go && (waddr == VAL_ADDR);
    assign rd_ctrl_hit[g] = raddr == SC_ADDR;
    assign rd_val_hit[g] = raddr == VAL_ADDR;
    assign rd_ctrl[g] = rd_go && rd_ctrl_hit[g];
    assign disabled[g] = (g != 0) && link0;
    if (g == 0) begin : g_src
      assign cmp_value[g] = (link0 && s_ff.active) ? ch_value[1] : ch_value[0];
    end else begin : g_src
      assign cmp_value[g] = ch_value[g];
    end
    ccmt_chan #(
      .CAN_LINK(g == 0)
    ) u_chan (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .count_i(s_ff.count),
      .cnt_new_i(s_ff.cnt_new),
      .ovf_i(ovf),
      .cmp_value_i(cmp_value[g]),
      .disabled_i(disabled[g]),
      .wr_ctrl_i(wr_ctrl[g]),
      .rd_ctrl_i(rd_ctrl[g]),
      .wr_val_i(wr_val[g]),
      .wdata_i(s_axi_wdata_i),
      .wstrb_i(s_axi_wstrb_i),
      .ctrl_o(ch_ctrl[g]),
      .value_o(ch_value[g]),
      .irq_o(chan_irq_o[g]),
      .pin_i(chan_pin_i[g]),
      .pin_o(chan_pin_o[g]),
      .pin_oe_o(chan_pin_oe_o[g])
    );
  end

  // ==========================================================================
  // Read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    if (raddr == `CCMT_ADDR_TSC) begin
      rd_mux[7:0] = {s_ff.ovf_flag, s_ff.overflow_irq_enable, s_ff.stop, 2'h0, s_ff.ps};
    end else if (raddr == `CCMT_ADDR_CNT) begin
      rd_mux[15:0] = s_ff.count;
    end else if (raddr == `CCMT_ADDR_MOD) begin
      rd_mux[15:0] = s_ff.modulo;
    end else begin
      rd_ok = 1'b0;
      for (int i = 0; i < NCH; i++) begin
        if (rd_ctrl_hit[i]) begin
          rd_mux[7:0] = ch_ctrl[i];
          rd_ok = 1'b1;
        end
        if (rd_val_hit[i]) begin
          rd_mux[15:0] = ch_value[i];
          rd_ok = 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_s = s_ff;
    // Prescaler and counter
    if (!s_ff.stop) begin
      nxt_s.presc = s_ff.presc + 7'h01;
    end
    nxt_s.cnt_new = tick;
    if (tick) begin
      if (s_ff.count == s_ff.modulo) begin
        nxt_s.count = 16'h0000;
      end else begin
        nxt_s.count = s_ff.count + 16'h0001;
      end
    end
    // Overflow flag: read while set arms, writing zero then clears
    if (rd_go && (raddr == `CCMT_ADDR_TSC) && s_ff.ovf_flag) begin
      nxt_s.ovf_armed = 1'b1;
    end
    // Bus responses
    if (s_ff.bvalid && s_axi_bready_i) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.rvalid && s_axi_rready_i) begin
      nxt_s.rvalid = 1'b0;
    end
    if (rd_go) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = rd_mux;
      nxt_s.rresp = rd_ok ? `CCMT_RESP_OKAY : `CCMT_RESP_SLVERR;
    end
    if (wr_go) begin
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = (|wr_ctrl || |wr_val || waddr == `CCMT_ADDR_TSC ||
        waddr == `CCMT_ADDR_MOD || waddr == `CCMT_ADDR_CNT) ?
        `CCMT_RESP_OKAY : `CCMT_RESP_SLVERR;
    end
    // Timer status and control write
    if (wr_go && (waddr == `CCMT_ADDR_TSC) && s_axi_wstrb_i[0]) begin
      if (!s_axi_wdata_i[`CCMT_TSC_OVF] && s_ff.ovf_armed) begin
        nxt_s.ovf_flag = 1'b0;
      end
      nxt_s.ovf_armed = 1'b0;
      nxt_s.overflow_irq_enable = s_axi_wdata_i[`CCMT_TSC_OVERFLOW_IRQ_ENABLE];
      nxt_s.stop = s_axi_wdata_i[`CCMT_TSC_STOP];
      nxt_s.ps = s_axi_wdata_i[`CCMT_TSC_PS_MSB:`CCMT_TSC_PS_LSB];
      if (s_axi_wdata_i[`CCMT_TSC_RST]) begin
        nxt_s.count = 16'h0000;
        nxt_s.presc = 7'h00;
        nxt_s.cnt_new = 1'b0;
      end
    end
    // Modulo write; high lane alone holds the overflow flag off until low lane
    if (wr_go && (waddr == `CCMT_ADDR_MOD)) begin
      if (s_axi_wstrb_i[1]) begin
        nxt_s.modulo[15:8] = s_axi_wdata_i[15:8];
        nxt_s.mod_inhibit = 1'b1;
      end
      if (s_axi_wstrb_i[0]) begin
        nxt_s.modulo[7:0] = s_axi_wdata_i[7:0];
        nxt_s.mod_inhibit = 1'b0;
      end
    end
    // Overflow event wins over a clear in the same cycle
    if (ovf && !s_ff.mod_inhibit) begin
      nxt_s.ovf_flag = 1'b1;
      nxt_s.ovf_armed = 1'b0;
    end
    // Buffered pair selection
    if (!link0) begin
      nxt_s.active = 1'b0;
      nxt_s.pending = 1'b0;
    end else begin
      if (wr_val[1]) begin
        nxt_s.pending = 1'b1;
      end else if (wr_val[0]) begin
        nxt_s.pending = 1'b0;
      end
      if (ovf) begin
        nxt_s.active = nxt_s.pending;
      end
    end
    if (reset_i) begin
      nxt_s = '0;
      nxt_s.modulo = `CCMT_MOD_RST;
      nxt_s.ps = `CCMT_PS_RST;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    s_ff <= nxt_s;
  end

  assign ovf_irq_o = s_ff.ovf_flag && s_ff.overflow_irq_enable;

endmodule

//--- ccmt_timer_checker.sv
// Assertions on the bus and output ports of the capture/compare timer
`timescale 1ns/1ps
`include "ccmt_regs.svh"

module ccmt_timer_checker #(
  parameter int ADDR_W = 8,
  parameter int NCH = 2
) (
  // Watched ports of the timer
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic ovf_irq_o,
  input wire logic [NCH-1:0] chan_irq_o,
  input wire logic [NCH-1:0] chan_pin_oe_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  // ==========================================================================
  // Handshake steps
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_wvalid_i && s_axi_awready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  AST_WR_READY: assert property (
    s_axi_awready_o == (s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o)
    && s_axi_wready_o == s_axi_awready_o) else $error("write ready wrong");
  AST_WR_RESP: assert property (
    s_wr_take |=> s_axi_bvalid_o) else $error("write response late");
  AST_B_HOLD: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  AST_RD_READY: assert property (
    s_axi_arready_o == !s_axi_rvalid_o) else $error("read ready wrong");
  AST_RD_RESP: assert property (
    s_rd_take ##1 (s_axi_rvalid_o && s_axi_rready_i) |=> !s_axi_rvalid_o)
    else $error("read response wrong");
  AST_R_HOLD: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  AST_UNMAPPED: assert property (
    s_rd_take and s_axi_araddr_i >= 8'h1C |=> s_axi_rresp_o == `CCMT_RESP_SLVERR
    && s_axi_rdata_o == 32'h0) else $error("unmapped read answered");
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    reset_i |=> !s_axi_bvalid_o && !s_axi_rvalid_o && !ovf_irq_o && chan_irq_o == '0
    && chan_pin_oe_o == '0) else $error("outputs active after reset");
endmodule

bind ccmt_timer ccmt_timer_checker #(.ADDR_W(ADDR_W), .NCH(NCH)) u_checker (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .ovf_irq_o(ovf_irq_o), .chan_irq_o(chan_irq_o),
  .chan_pin_oe_o(chan_pin_oe_o)
);

//--- ccmt_pin_model.sv
// External source on the two channel pins
`timescale 1ns/1ps

module ccmt_pin_model (
  // Level wanted by the outside source
  input wire logic [1:0] lvl_i,
  // Timer side of the pins
  input wire logic [1:0] pin_o_i,
  input wire logic [1:0] pin_oe_i,
  output logic [1:0] pin_i_o
);
  // The timer owns a pin while it enables it, the outside source otherwise
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_i_o[i] = pin_oe_i[i] ? pin_o_i[i] : lvl_i[i];
    end
  end
endmodule

//--- tb_ccmt_timer.sv
// Self-checking testbench of the capture/compare timer
`timescale 1ns/1ps
`include "ccmt_regs.svh"

module tb_ccmt_timer;
  // ==========================================================================
  // Signals
  localparam logic [7:0] A_TSC = `CCMT_ADDR_TSC;
  localparam logic [7:0] A_CNT = `CCMT_ADDR_CNT;
  localparam logic [7:0] A_MOD = `CCMT_ADDR_MOD;
  localparam logic [7:0] A_CS0 = `CCMT_ADDR_CH0_SC;
  localparam logic [7:0] A_CV0 = `CCMT_ADDR_CH0_VAL;
  localparam logic [7:0] A_CS1 = A_CS0 + `CCMT_CH_STRIDE;
  localparam logic [7:0] A_CV1 = A_CV0 + `CCMT_CH_STRIDE;
  logic sys_clk_i, reset_i, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, oirq, hit;
  logic [7:0] awa, ara;
  logic [31:0] wdt, rdt, rd_d;
  logic [3:0] wst;
  logic [1:0] bre, rre, rd_r, wr_r, cirq, pin, pout, poe, lvl;
  int n_mismatch, num_checks;

  ccmt_timer dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wdt), .s_axi_wstrb_i(wst), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_bresp_o(bre), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdt), .s_axi_rresp_o(rre), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .ovf_irq_o(oirq), .chan_irq_o(cirq), .chan_pin_i(pin), .chan_pin_o(pout),
    .chan_pin_oe_o(poe)
  );
  ccmt_pin_model u_pins (.lvl_i(lvl), .pin_o_i(pout), .pin_oe_i(poe), .pin_i_o(pin));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    awa <= a;
    wdt <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do @(negedge sys_clk_i); while (!(awr && wrd));
    @(posedge sys_clk_i);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(negedge sys_clk_i); while (!bv);
    wr_r = bre;
    @(posedge sys_clk_i);
    br <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(negedge sys_clk_i); while (!arr);
    @(posedge sys_clk_i);
    arv <= 1'b0;
    do @(negedge sys_clk_i); while (!rv);
    rd_d = rdt;
    rd_r = rre;
    @(posedge sys_clk_i);
    rr <= 1'b0;
  endtask
  // Flag clear: read while set, then write the flag bit as 0
  task automatic clr(input logic [7:0] a, input logic [31:0] d);
    rd(a);
    wr(a, d);
  endtask
  // Waits for the overflow (b < 0) or a channel interrupt
  task automatic wt(input int b);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
      hit = (b < 0) ? oirq : cirq[b];
    end while (hit !== 1'b1 && n < 300);
    @(posedge sys_clk_i);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    wr(A_CV0, 32'h1234);
    reset_i <= 1'b1;
    cyc(16);
    reset_i <= 1'b0;
    rd(A_MOD);
    chk("modulo", 32'hFFFF, rd_d);
    rd(A_TSC);
    chk("timer ctrl", 32'h0, rd_d);
    rd(A_CV0);
    chk("ch0 value", 32'h1234, rd_d);
    rd(8'h1C);
    chk("unmapped resp", 32'(`CCMT_RESP_SLVERR), 32'(rd_r));
    wr(8'h1C, 32'h0);
    chk("unmapped wr resp", 32'(`CCMT_RESP_SLVERR), 32'(wr_r));
  endtask
  task automatic t_presc;
    logic [31:0] c;
    for (int ps = 0; ps < 7; ps++) begin
      wr(A_TSC, 32'h30 | ps);
      wr(A_TSC, 32'(ps));
      cyc(256);
      wr(A_TSC, 32'h20 | ps);
      rd(A_CNT);
      c = rd_d;
      chk("tick count", 32'h1, 32'(c >= (256 >> ps) && c <= (270 >> ps) + 1));
      rd(A_CNT);
      chk("stopped count", c, rd_d);
    end
  endtask
  task automatic t_ovf;
    wr(A_TSC, 32'h30);
    wr(A_MOD, 32'h0F);
    wr(A_TSC, 32'h40);
    wt(-1);
    chk("ovf irq", 32'h1, 32'(hit));
    wr(A_TSC, 32'h60);
    rd(A_CNT);
    chk("wrapped", 32'h1, 32'(rd_d < 32'h10));
    clr(A_TSC, 32'h60);
    chk("ovf cleared", 32'h0, 32'(oirq));
  endtask
  task automatic t_cmp;
    wr(A_TSC, 32'h30);
    wr(A_MOD, 32'h3F);
    wr(A_CV0, 32'h20);
    wr(A_CS0, 32'h10);
    // Pin level follows the control write one edge later
    @(negedge sys_clk_i);
    chk("preset pin", 32'h0, 32'(pout[0]));
    for (int i = 0; i < 3; i++) begin
      wr(A_TSC, 32'h20);
      clr(A_CS0, 32'h50 | ((3 - i) << 2));
      wr(A_TSC, 32'h00);
      wt(0);
      chk("cmp irq", 32'h1, 32'(hit));
      chk("cmp pin", 32'(i != 1), 32'(pout[0]));
      chk("cmp oe", 32'h1, 32'(poe[0]));
    end
    // Lower the value inside the compare handler, raise it after overflow
    wr(A_CV0, 32'h10);
    clr(A_CS0, 32'h54);
    wt(0);
    rd(A_CNT);
    chk("lowered cmp", 32'h1, 32'(rd_d >= 32'h10 && rd_d < 32'h20));
    clr(A_CS0, 32'h54);
    clr(A_TSC, 32'h40);
    wt(-1);
    wr(A_CV0, 32'h30);
    wt(0);
    rd(A_CNT);
    chk("raised cmp", 32'h1, 32'(rd_d >= 32'h30 && rd_d < 32'h3F));
  endtask
  task automatic t_cap;
    logic [31:0] c;
    wr(A_MOD, 32'hFFFF);
    wr(A_TSC, 32'h10);
    for (int m = 1; m < 4; m++) begin
      clr(A_CS1, 32'(m << 2));
      lvl[1] <= 1'b1;
      cyc(6);
      rd(A_CS1);
      chk("rise flag", 32'(m & 1), 32'(rd_d[7]));
      wr(A_CS1, 32'(m << 2));
      lvl[1] <= 1'b0;
      cyc(6);
      rd(A_CS1);
      chk("fall flag", 32'(m >> 1), 32'(rd_d[7]));
    end
    rd(A_CNT);
    c = rd_d;
    lvl[1] <= 1'b1;
    cyc(6);
    rd(A_CV1);
    chk("capture time", 32'h1, 32'(rd_d > c && rd_d < c + 10));
    c = rd_d;
    lvl[1] <= 1'b0;
    cyc(6);
    rd(A_CV1);
    chk("capture again", 32'h1, 32'(rd_d > c));
  endtask
  task automatic t_link;
    wr(A_CS1, 32'h14);
    chk("ch1 oe", 32'h1, 32'(poe[1]));
    wr(A_CS0, 32'h34);
    rd(A_CS1);
    chk("linked ch1 ctrl", 32'h0, rd_d);
    chk("linked ch1 oe", 32'h0, 32'(poe[1]));
    rd(A_CS0);
    chk("link bit", 32'h1, 32'(rd_d[5]));
    chk("ch0 oe", 32'h1, 32'(poe[0]));
  endtask
  task automatic t_buf;
    wr(A_TSC, 32'h30);
    wr(A_MOD, 32'h3F);
    wr(A_CV0, 32'h10);
    wr(A_CV1, 32'h30);
    clr(A_CS0, 32'h74);
    wr(A_TSC, 32'h00);
    wt(0);
    rd(A_CNT);
    chk("buffered first", 32'h1, 32'(rd_d >= 32'h10 && rd_d < 32'h20));
    clr(A_CS0, 32'h74);
    wt(0);
    rd(A_CNT);
    chk("buffered next", 32'h1, 32'(rd_d >= 32'h30 && rd_d < 32'h3F));
    clr(A_CS0, 32'h6A);
    wt(0);
    chk("cleared pin", 32'h0, 32'(pout[0]));
    clr(A_TSC, 32'h40);
    wt(-1);
    chk("overflow toggle", 32'h1, 32'(pout[0]));
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #1600000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    reset_i = 1'b1;
    awa = 8'h00;
    ara = 8'h00;
    wdt = 32'h0;
    wst = 4'hF;
    awv = 1'b0;
    wv = 1'b0;
    br = 1'b0;
    arv = 1'b0;
    rr = 1'b0;
    lvl = 2'h0;
    cyc(16);
    reset_i <= 1'b0;
    t_reset;
    t_presc;
    t_ovf;
    t_cmp;
    t_cap;
    t_link;
    t_buf;
    give_verdict;
  end
endmodule
